/* File: bench/fwc_ctrl_assertions.sv */
// Port-level checks on the flash command controller.
// Assumes a bind onto fwc_ctrl; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module fwc_ctrl_chk
  import fwc_pkg::*;
(
  input wire logic        I_CLOCK,
  input wire logic        I_RST_N,
  input wire logic        I_REQ_VALID,
  input wire fwc_op_t     I_REQ_OP,
  input wire logic [19:0] I_REQ_ADDR,
  input wire logic [15:0] I_REQ_DATA,
  input wire logic        I_ERASE_DONE,
  input wire logic [15:0] I_FL_DQ_IN,
  input wire logic        O_REQ_READY,
  input wire logic        O_DONE,
  input wire logic        O_REJECT,
  input wire logic [15:0] O_RD_DATA,
  input wire fwc_mode_t   O_MODE,
  input wire logic        O_FL_CE_N,
  input wire logic        O_FL_WE_N,
  input wire logic        O_FL_OE_N,
  input wire logic [19:0] O_FL_ADDR,
  input wire logic [15:0] O_FL_DQ_OUT,
  input wire logic        O_FL_DQ_OE_N
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);

  we_in_ce_a: assert property (!O_FL_WE_N |-> !O_FL_CE_N && !O_FL_DQ_OE_N)
    else $error("write strobe outside select");
  rd_no_we_a: assert property (!(!O_FL_WE_N && !O_FL_OE_N))
    else $error("read and write strobes together");
  wr_hold_a: assert property (!O_FL_WE_N && $past(!O_FL_WE_N) |->
    $stable(O_FL_ADDR) && $stable(O_FL_DQ_OUT)) else $error("write bus moved");
  we_pulse_a: assert property ($fell(O_FL_WE_N) |-> ##1 !O_FL_WE_N ##1 O_FL_WE_N)
    else $error("write pulse not two cycles");
  rej_idle_a: assert property (O_REJECT |-> O_REQ_READY && O_FL_CE_N && !O_DONE)
    else $error("refusal touched the pins");
  take_a: assert property (I_REQ_VALID && O_REQ_READY |=> O_REJECT || !O_REQ_READY)
    else $error("request neither taken nor refused");
  busy_end_a: assert property ($fell(O_REQ_READY) |-> ##[1:60] O_DONE)
    else $error("operation never finished");
  susp_src_a: assert property ($rose(O_MODE.suspended) |->
    $past(O_MODE.erasing) && !$past(O_MODE.chip_erasing)) else $error("bad suspend");
  byp_only_a: assert property (O_MODE.bypass |-> !O_MODE.erasing && !O_MODE.autosel)
    else $error("mode set inside bypass");

  cover property (O_DONE);
  cover property (O_REJECT);
  cover property ($rose(O_MODE.suspended));
endmodule : fwc_ctrl_chk
`default_nettype wire

/* File: bench/fwc_flash_model.sv */
// Clockless model of the word-mode flash behind the controller.
// Assumes the bench merges its data output with the controller's drive.
`timescale 1ns/100ps
`default_nettype none
module fwc_flash_model
  import fwc_pkg::*;
#(
  parameter logic [15:0] MFR_CODE = 16'h00c3, // Arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h5a11, // Arbitrary value
  parameter logic [7:0]  PROT_SEC = 8'h05
)(
  input  wire logic        i_ce_n,
  input  wire logic        i_we_n,
  input  wire logic        i_oe_n,
  input  wire logic [19:0] i_addr,
  input  wire logic [15:0] i_dq,
  output var  logic [15:0] o_dq
);
  logic [19:0] wa[$];
  logic [15:0] wd[$];
  logic [19:0] al;
  logic [1:0]  cyc;
  logic        asel;
  logic [15:0] last;

  initial
  begin
    cyc = 2'h0;
    asel = 1'b0;
    last = 16'h0000;
    al = 20'h00000;
  end

  task automatic wr(input logic [19:0] a, input logic [15:0] d);
    wa.push_back(a);
    wd.push_back(d);
    if (d[7:0] == 8'hf0)
    begin
      asel = 1'b0;
      cyc = 2'h0;
    end
    else if (asel && d[7:0] == 8'h00)
      asel = 1'b0;
    else if (cyc == 2'h0 && a[10:0] == 11'h555 && d[7:0] == 8'haa)
      cyc = 2'h1;
    else if (cyc == 2'h1 && a[10:0] == 11'h2aa && d[7:0] == 8'h55)
      cyc = 2'h2;
    else
    begin
      if (cyc == 2'h2 && a[10:0] == 11'h555 && d[7:0] == 8'h90)
        asel = 1'b1;
      cyc = 2'h0;
    end
  endtask : wr

  function automatic logic [15:0] rv(input logic [19:0] a);
    if (!asel)
      return a[15:0] ^ 16'h3c5a;
    case (a[7:0])
      8'h00:   return MFR_CODE;
      8'h01:   return DEV_CODE;
      8'h02:   return {15'h0000, a[19:12] == PROT_SEC};
      8'h03:   return 16'h0009;
      default: return 16'h0000;
    endcase
  endfunction : rv

  // Sequence moves only on strobe edges, never on time
  always @(negedge i_we_n or negedge i_ce_n)
    if (!i_we_n && !i_ce_n)
      al = i_addr;
  always @(posedge i_we_n or posedge i_ce_n)
    if (i_we_n != i_ce_n)
      wr(al, i_dq);

  // Released bus shows the inverse, no pull on these lines
  always @*
    if (!i_ce_n && !i_oe_n)
    begin
      o_dq = rv(i_addr);
      last = o_dq;
    end
    else
      o_dq = ~last;
endmodule : fwc_flash_model
`default_nettype wire

/* File: bench/tb_fwc_ctrl.sv */
// Self-checking bench for the flash command controller.
// Assumes the flash model and checker files compile first.
`timescale 1ns/100ps
`default_nettype none
module tb_fwc_ctrl
  import fwc_pkg::*;
;
  logic        clk, rst_n, vld, edone, rdy, done, rej, ce_n, we_n, oe_n, dq_oe_n;
  fwc_op_t     op;
  fwc_mode_t   mode;
  logic [19:0] ra, fa, fl_a;
  logic [15:0] pd, rdt, dq_out, m_q, dq, fd;
  logic [19:0] ea[$];
  logic [15:0] ed[$];
  int          num_errors, n_checks, cycles, seed;

  assign dq = dq_oe_n ? m_q : dq_out;
  fwc_ctrl dut (.I_CLOCK(clk), .I_RST_N(rst_n), .I_REQ_VALID(vld), .I_REQ_OP(op),
    .I_REQ_ADDR(ra), .I_REQ_DATA(pd), .I_ERASE_DONE(edone), .I_FL_DQ_IN(dq),
    .O_REQ_READY(rdy), .O_DONE(done), .O_REJECT(rej), .O_RD_DATA(rdt), .O_MODE(mode),
    .O_FL_CE_N(ce_n), .O_FL_WE_N(we_n), .O_FL_OE_N(oe_n), .O_FL_ADDR(fl_a),
    .O_FL_DQ_OUT(dq_out), .O_FL_DQ_OE_N(dq_oe_n));
  fwc_flash_model fl (.i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n), .i_addr(fl_a),
    .i_dq(dq), .o_dq(m_q));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      $display("mismatch at %0t: run hung", $time);
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic p(input logic [19:0] a, input logic [15:0] d);
    ea.push_back(a);
    ed.push_back(d);
  endtask : p

  task automatic u3(input logic [15:0] c);
    p(20'h00555, 16'h00aa);
    p(20'h002aa, 16'h0055);
    if (c != 16'hffff)
      p(20'h00555, c);
  endtask : u3

  // Expected write cycles of each operation
  task automatic ex(input fwc_op_t o, input logic [19:0] a, input logic [15:0] d);
    case (o)
      OP_RESET:                     p(20'h00555, 16'h00f0);
      OP_AUTOSEL, OP_SECSI_EXIT:    u3(16'h0090);
      OP_SECSI_ENTER:               u3(16'h0088);
      OP_CFI:                       p(20'h00055, 16'h0098);
      OP_PROGRAM:                   u3(16'h00a0);
      OP_BYP_ENTER:                 u3(16'h0020);
      OP_BYP_PROGRAM:               p(20'h00000, 16'h00a0);
      OP_BYP_RESET:                 p(20'h00000, 16'h0090);
      OP_CHIP_ERASE, OP_SECT_ERASE: u3(16'h0080);
      OP_SUSPEND:                   p(20'h00000, 16'h00b0);
      OP_RESUME:                    p(20'h00000, 16'h0030);
      default: ;
    endcase
    case (o)
      OP_SECSI_EXIT:                p(20'h00000, 16'h0000);
      OP_PROGRAM, OP_BYP_PROGRAM:   p(a, d);
      OP_BYP_RESET:                 p(20'h00000, 16'h00f0);
      OP_CHIP_ERASE:                u3(16'h0010);
      OP_SECT_ERASE:                u3(16'hffff);
      default: ;
    endcase
    if (o == OP_SECT_ERASE || o == OP_SECT_ADD)
      p({a[19:12], 12'h000}, 16'h0030);
  endtask : ex

  task automatic run(input fwc_op_t o, input logic [19:0] a, input logic [15:0] d,
                     input logic r);
    int k;
    ea.delete();
    ed.delete();
    fl.wa.delete();
    fl.wd.delete();
    if (!r)
      ex(o, a, d);
    // A clock edge between requests, so valid never falls and rises at once
    @(negedge clk);
    for (k = 0; k < 100 && rdy !== 1'b1; k++)
      @(negedge clk);
    op = o;
    ra = a;
    pd = d;
    vld = 1'b1;
    @(negedge clk);
    vld = 1'b0;
    for (k = 0; k < 100 && done !== 1'b1 && rej !== 1'b1; k++)
      @(negedge clk);
    chk({done, rej}, {~r, r});
    chk(fl.wa.size(), ea.size());
    foreach (ea[i])
    begin
      chk(fl.wa[i], ea[i]);
      chk(fl.wd[i], ed[i]);
    end
  endtask : run

  task automatic edone_pulse();
    @(negedge clk);
    edone = 1'b1;
    @(negedge clk);
    edone = 1'b0;
  endtask : edone_pulse

  initial
  begin
    seed = 72;
    {vld, edone, rst_n, ra, pd} = '0;
    op = OP_READ;
    repeat (3) @(negedge clk);
    chk({ce_n, we_n, oe_n, dq_oe_n, mode}, {4'hf, 7'h00});
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      fa = 20'($random(seed));
      run(OP_READ, fa, 16'h0000, 1'b0);
      chk(rdt, fa[15:0] ^ 16'h3c5a);
    end
    $display("test array reads done");
    fa = 20'($random(seed));
    fd = 16'($random(seed));
    run(OP_RESET, 20'h12345, 16'h0000, 1'b0);
    run(OP_PROGRAM, fa, fd, 1'b0);
    run(OP_CFI, 20'h00000, 16'h0000, 1'b0);
    run(OP_AUTOSEL, 20'h00000, 16'h0000, 1'b1);
    run(OP_RESET, 20'h00000, 16'h0000, 1'b0);
    run(OP_AUTOSEL, 20'h00000, 16'h0000, 1'b0);
    chk(rdt, fl.MFR_CODE);
    run(OP_READ, 20'h00003, 16'h0000, 1'b0);
    chk(rdt, 16'h0009);
    run(OP_READ, {fl.PROT_SEC, 12'h002}, 16'h0000, 1'b0);
    chk(rdt, 16'h0001);
    run(OP_READ, 20'hf0002, 16'h0000, 1'b0);
    chk(rdt, 16'h0000);
    run(OP_RESET, 20'h00000, 16'h0000, 1'b0);
    run(OP_SECSI_ENTER, 20'h00000, 16'h0000, 1'b0);
    run(OP_SECSI_EXIT, 20'h00000, 16'h0000, 1'b0);
    run(OP_READ, 20'h00001, 16'h0000, 1'b0);
    chk(rdt, 16'h3c5b);
    $display("test identification done");
    run(OP_BYP_ENTER, 20'h00000, 16'h0000, 1'b0);
    run(OP_PROGRAM, fa, fd, 1'b1);
    run(OP_AUTOSEL, 20'h00000, 16'h0000, 1'b1);
    run(OP_BYP_PROGRAM, fa ^ 20'h00f0f, ~fd, 1'b0);
    run(OP_BYP_RESET, 20'h00000, 16'h0000, 1'b0);
    run(OP_BYP_ENTER, 20'h00000, 16'h0000, 1'b0);
    rst_n = 1'b0;
    @(negedge clk);
    chk({rdy, mode}, 8'h00);
    rst_n = 1'b1;
    run(OP_RESET, 20'h00000, 16'h0000, 1'b0);
    chk(mode, 7'h00);
    $display("test bypass done");
    run(OP_SUSPEND, 20'h00000, 16'h0000, 1'b1);
    run(OP_RESUME, 20'h00000, 16'h0000, 1'b1);
    run(OP_CHIP_ERASE, 20'h00000, 16'h0000, 1'b0);
    run(OP_SUSPEND, 20'h00000, 16'h0000, 1'b1);
    edone_pulse();
    fa = 20'($random(seed));
    run(OP_SECT_ERASE, fa, 16'h0000, 1'b0);
    run(OP_SECT_ADD, fa ^ 20'h81000, 16'h0000, 1'b0);
    run(OP_SUSPEND, 20'h00000, 16'h0000, 1'b0);
    run(OP_CFI, 20'h00000, 16'h0000, 1'b1);
    run(OP_PROGRAM, fa ^ 20'h40000, fd, 1'b0);
    run(OP_AUTOSEL, 20'h00000, 16'h0000, 1'b0);
    chk(rdt, fl.MFR_CODE);
    run(OP_RESUME, 20'h00000, 16'h0000, 1'b1);
    run(OP_RESET, 20'h00000, 16'h0000, 1'b0);
    run(OP_RESUME, 20'h00000, 16'h0000, 1'b0);
    run(OP_RESUME, 20'h00000, 16'h0000, 1'b1);
    edone_pulse();
    chk(mode, 7'h00);
    $display("test erase done");
    complete_run();
  end
endmodule : tb_fwc_ctrl

bind fwc_ctrl fwc_ctrl_chk u_chk (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N),
  .I_REQ_VALID(I_REQ_VALID), .I_REQ_OP(I_REQ_OP), .I_REQ_ADDR(I_REQ_ADDR),
  .I_REQ_DATA(I_REQ_DATA), .I_ERASE_DONE(I_ERASE_DONE), .I_FL_DQ_IN(I_FL_DQ_IN),
  .O_REQ_READY(O_REQ_READY), .O_DONE(O_DONE), .O_REJECT(O_REJECT), .O_RD_DATA(O_RD_DATA),
  .O_MODE(O_MODE), .O_FL_CE_N(O_FL_CE_N), .O_FL_WE_N(O_FL_WE_N), .O_FL_OE_N(O_FL_OE_N),
  .O_FL_ADDR(O_FL_ADDR), .O_FL_DQ_OUT(O_FL_DQ_OUT), .O_FL_DQ_OE_N(O_FL_DQ_OE_N));
`default_nettype wire

/* File: src/fwc_bus_cycle.sv */
// One flash bus cycle, read or write, on the chip-select, write and output strobes.
// Assumes the request fields stay stable from i_start until o_done.
`timescale 1ns/100ps
`default_nettype none
module fwc_bus_cycle
  import fwc_pkg::*;
(
  input  wire logic      i_clk,
  input  wire logic      i_rst_n,
  input  wire logic      i_start,
  input  wire fwc_cyc_t  i_cyc,
  input  wire logic [15:0] i_dq_in,
  output var  fwc_pins_t o_pins,
  output var  logic      o_done,
  output var  logic [15:0] o_rdata
);

  typedef enum logic [3:0] {
    BC_IDLE   = 4'b0001,
    BC_SETUP  = 4'b0010,
    BC_STROBE = 4'b0100,
    BC_HOLD   = 4'b1000
  } fwc_bc_state_t;

  typedef struct packed {
    fwc_bc_state_t st;
    logic [3:0]    cnt;
    logic          rd;
    fwc_pins_t     pins;
    logic          done;
    logic [15:0]   rdata;
  } fwc_bc_t;

  localparam fwc_pins_t PINS_IDLE = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 20'h00000,
                                      dq_out: 16'h0000, dq_oe_n: 1'b1};

  fwc_bc_t s_reg;
  fwc_bc_t s_next;

  always_comb
  begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    case (s_reg.st)
      BC_IDLE:
      begin
        if (i_start)
        begin
          // Address and data settle before either strobe edge
          s_next.rd           = i_cyc.rd;
          s_next.pins.addr    = i_cyc.addr;
          s_next.pins.dq_out  = i_cyc.data;
          s_next.pins.dq_oe_n = i_cyc.rd;
          s_next.pins.ce_n    = 1'b0;
          s_next.cnt          = 4'(SETUP_CYC - 1);
          s_next.st           = BC_SETUP;
        end
      end
      BC_SETUP:
      begin
        if (s_reg.cnt == 4'h0)
        begin
          // Write strobe falls last, so it is the address-latching edge
          s_next.pins.we_n = s_reg.rd;
          s_next.pins.oe_n = !s_reg.rd;
          s_next.cnt       = s_reg.rd ? 4'(ACCESS_CYC - 1) : 4'(WRITE_CYC - 1);
          s_next.st        = BC_STROBE;
        end
        else
          s_next.cnt = s_reg.cnt - 4'h1;
      end
      BC_STROBE:
      begin
        if (s_reg.cnt == 4'h0)
        begin
          // Write strobe rises first; data is held past it
          s_next.pins.we_n = 1'b1;
          s_next.pins.oe_n = 1'b1;
          if (s_reg.rd)
            s_next.rdata = i_dq_in;
          s_next.cnt = 4'(HOLD_CYC - 1);
          s_next.st  = BC_HOLD;
        end
        else
          s_next.cnt = s_reg.cnt - 4'h1;
      end
      BC_HOLD:
      begin
        if (s_reg.cnt == 4'h0)
        begin
          s_next.pins.ce_n    = 1'b1;
          s_next.pins.dq_oe_n = 1'b1;
          s_next.done         = 1'b1;
          s_next.st           = BC_IDLE;
        end
        else
          s_next.cnt = s_reg.cnt - 4'h1;
      end
      default:
      begin
        s_next.pins = PINS_IDLE;
        s_next.st   = BC_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      s_reg <= '{st: BC_IDLE, cnt: 4'h0, rd: 1'b0, pins: PINS_IDLE, done: 1'b0,
                 rdata: 16'h0000};
    else
      s_reg <= s_next;
  end

  assign o_pins  = s_reg.pins;
  assign o_done  = s_reg.done;
  assign o_rdata = s_reg.rdata;

endmodule : fwc_bus_cycle
`default_nettype wire

/* File: src/fwc_ctrl.sv */
// Host-side command controller for a word-mode boot-sector NOR flash.
// Assumes the flash pins are wired direct and data inputs are synchronous to I_CLOCK.
`timescale 1ns/100ps
`default_nettype none
module fwc_ctrl
  import fwc_pkg::*;
(
  input  wire logic        I_CLOCK,
  input  wire logic        I_RST_N,
  input  wire logic        I_REQ_VALID,
  input  wire fwc_op_t     I_REQ_OP,
  input  wire logic [19:0] I_REQ_ADDR,
  input  wire logic [15:0] I_REQ_DATA,
  input  wire logic        I_ERASE_DONE,
  input  wire logic [15:0] I_FL_DQ_IN,
  output var  logic        O_REQ_READY,
  output var  logic        O_DONE,
  output var  logic        O_REJECT,
  output var  logic [15:0] O_RD_DATA,
  output var  fwc_mode_t   O_MODE,
  output var  logic        O_FL_CE_N,
  output var  logic        O_FL_WE_N,
  output var  logic        O_FL_OE_N,
  output var  logic [19:0] O_FL_ADDR,
  output var  logic [15:0] O_FL_DQ_OUT,
  output var  logic        O_FL_DQ_OE_N
);

  typedef enum logic [2:0] {
    M_IDLE  = 3'b001,
    M_ISSUE = 3'b010,
    M_WAIT  = 3'b100
  } fwc_m_state_t;

  typedef struct packed {
    fwc_m_state_t st;
    fwc_op_t      op;
    logic [19:0]  addr;
    logic [15:0]  data;
    logic [2:0]   step;
    fwc_mode_t    mode;
    logic [10:0]  win;
    logic         start;
    logic         ready;
    logic         done;
    logic         reject;
    logic [15:0]  rdata;
  } fwc_ctrl_t;

  localparam logic [10:0] WIN_LOAD  = 11'(ERASE_WIN_CYC);
  localparam logic [10:0] WIN_GUARD = 11'(WIN_GUARD_CYC);

  function automatic logic [19:0] sector_of(input logic [19:0] a);
    return {a[SECTOR_MSB:SECTOR_LSB], 12'h000};
  endfunction : sector_of

  function automatic logic [2:0] seq_len(input fwc_op_t op);
    case (op)
      OP_AUTOSEL, OP_SECSI_EXIT, OP_PROGRAM:   return 3'd4;
      OP_SECSI_ENTER, OP_BYP_ENTER:            return 3'd3;
      OP_BYP_PROGRAM, OP_BYP_RESET:            return 3'd2;
      OP_CHIP_ERASE, OP_SECT_ERASE:            return 3'd6;
      default:                                 return 3'd1;
    endcase
  endfunction : seq_len

  function automatic logic [15:0] third_cmd(input fwc_op_t op);
    case (op)
      OP_AUTOSEL, OP_SECSI_EXIT:    return CMD_AUTOSEL;
      OP_SECSI_ENTER:               return CMD_SECSI_ENTER;
      OP_PROGRAM:                   return CMD_PROGRAM;
      OP_BYP_ENTER:                 return CMD_BYPASS;
      default:                      return CMD_ERASE_SETUP;
    endcase
  endfunction : third_cmd

  // Sequences are built only from this table, so the flash never sees a stray write
  function automatic fwc_cyc_t cyc_of(input fwc_op_t op, input logic [2:0] step,
                                      input logic [19:0] a, input logic [15:0] d);
    fwc_cyc_t c;
    c = '{rd: 1'b0, addr: ADDR_UNLOCK1, data: D_UNLOCK1};
    case (op)
      OP_READ:     c = '{rd: 1'b1, addr: a, data: 16'h0000};
      OP_RESET:    c.data = CMD_RESET;
      OP_CFI:      c = '{rd: 1'b0, addr: ADDR_CFI, data: CMD_CFI};
      OP_SUSPEND:  c = '{rd: 1'b0, addr: ADDR_ANY, data: CMD_SUSPEND};
      OP_RESUME:   c = '{rd: 1'b0, addr: ADDR_ANY, data: CMD_RESUME};
      OP_SECT_ADD: c = '{rd: 1'b0, addr: sector_of(a), data: CMD_SECT_ERASE};
      OP_BYP_PROGRAM:
        c = (step == 3'd0) ? fwc_cyc_t'{rd: 1'b0, addr: ADDR_ANY, data: CMD_PROGRAM}
                           : fwc_cyc_t'{rd: 1'b0, addr: a, data: d};
      OP_BYP_RESET:
        c = '{rd: 1'b0, addr: ADDR_ANY,
              data: (step == 3'd0) ? CMD_AUTOSEL : CMD_RESET};
      default:
      begin
        case (step)
          3'd0, 3'd3: c = '{rd: 1'b0, addr: ADDR_UNLOCK1, data: D_UNLOCK1};
          3'd1, 3'd4: c = '{rd: 1'b0, addr: ADDR_UNLOCK2, data: D_UNLOCK2};
          3'd2:       c = '{rd: 1'b0, addr: ADDR_UNLOCK1, data: third_cmd(op)};
          default:    c = '{rd: 1'b0, addr: ADDR_UNLOCK1, data: CMD_CHIP_ERASE};
        endcase
        if (step == 3'd3 && op == OP_AUTOSEL)
          c = '{rd: 1'b1, addr: a, data: 16'h0000};
        if (step == 3'd3 && op == OP_SECSI_EXIT)
          c = '{rd: 1'b0, addr: ADDR_ANY, data: CMD_SECSI_EXIT};
        if (step == 3'd3 && op == OP_PROGRAM)
          c = '{rd: 1'b0, addr: a, data: d};
        if (step == 3'd5 && op == OP_SECT_ERASE)
          c = '{rd: 1'b0, addr: sector_of(a), data: CMD_SECT_ERASE};
      end
    endcase
    return c;
  endfunction : cyc_of

  function automatic logic allowed(input fwc_op_t op, input fwc_mode_t m,
                                   input logic [10:0] win);
    logic busy;
    logic quiet;
    busy  = m.chip_erasing | (m.erasing & ~m.suspended);
    quiet = ~m.bypass & ~m.erasing & ~m.chip_erasing & ~m.autosel & ~m.cfi;
    if (m.bypass)
      return op == OP_READ || op == OP_RESET || op == OP_BYP_PROGRAM ||
             op == OP_BYP_RESET;
    case (op)
      OP_READ:        return 1'b1;
      OP_RESET:       return ~busy;
      OP_AUTOSEL:     return ~busy & ~m.cfi;
      OP_SECSI_ENTER,
      OP_SECSI_EXIT:  return ~busy & ~m.erasing & ~m.cfi;
      OP_CFI:         return ~m.erasing & ~m.chip_erasing & ~m.cfi;
      OP_PROGRAM:     return ~busy & ~m.autosel & ~m.cfi;
      OP_BYP_ENTER,
      OP_CHIP_ERASE,
      OP_SECT_ERASE:  return quiet;
      OP_SECT_ADD:    return m.erasing & ~m.suspended & (win > WIN_GUARD);
      OP_SUSPEND:     return m.erasing & ~m.suspended;
      OP_RESUME:      return m.suspended & ~m.autosel;
      default:        return 1'b0;
    endcase
  endfunction : allowed

  fwc_ctrl_t    s_reg;
  fwc_ctrl_t    s_next;
  fwc_cyc_t     bc_cyc;
  fwc_pins_t    bc_pins;
  logic         bc_done;
  logic [15:0]  bc_rdata;

  assign bc_cyc = cyc_of(s_reg.op, s_reg.step, s_reg.addr, s_reg.data);

  fwc_bus_cycle u_cycle (
    .i_clk   (I_CLOCK),
    .i_rst_n (I_RST_N),
    .i_start (s_reg.start),
    .i_cyc   (bc_cyc),
    .i_dq_in (I_FL_DQ_IN),
    .o_pins  (bc_pins),
    .o_done  (bc_done),
    .o_rdata (bc_rdata)
  );

  always_comb
  begin
    s_next        = s_reg;
    s_next.start  = 1'b0;
    s_next.done   = 1'b0;
    s_next.reject = 1'b0;
    if (s_reg.win != 11'h000)
      s_next.win = s_reg.win - 11'h001;
    case (s_reg.st)
      M_IDLE:
      begin
        // Ready rises on the first edge after reset and stays up while idle
        s_next.ready = 1'b1;
        if (I_REQ_VALID && s_reg.ready)
        begin
          if (allowed(I_REQ_OP, s_reg.mode, s_reg.win))
          begin
            s_next.op    = I_REQ_OP;
            s_next.addr  = I_REQ_ADDR;
            s_next.data  = I_REQ_DATA;
            s_next.step  = 3'd0;
            s_next.ready = 1'b0;
            s_next.start = 1'b1;
            s_next.st    = M_WAIT;
          end
          else
            s_next.reject = 1'b1;
        end
      end
      M_ISSUE:
      begin
        s_next.start = 1'b1;
        s_next.st    = M_WAIT;
      end
      M_WAIT:
      begin
        if (bc_done)
        begin
          if (s_reg.step == seq_len(s_reg.op) - 3'd1)
          begin
            s_next.rdata = bc_rdata;
            s_next.done  = 1'b1;
            s_next.ready = 1'b1;
            s_next.st    = M_IDLE;
            case (s_reg.op)
              OP_RESET:
              begin
                // Suspend survives: leaving autoselect reverts to suspend mode
                s_next.mode.autosel = 1'b0;
                s_next.mode.cfi     = 1'b0;
                s_next.mode.bypass  = 1'b0;
              end
              OP_AUTOSEL:     s_next.mode.autosel = 1'b1;
              OP_SECSI_ENTER: s_next.mode.secsi = 1'b1;
              OP_SECSI_EXIT:
              begin
                s_next.mode.secsi   = 1'b0;
                s_next.mode.autosel = 1'b0;
              end
              OP_CFI:         s_next.mode.cfi = 1'b1;
              OP_BYP_ENTER:   s_next.mode.bypass = 1'b1;
              OP_BYP_RESET:   s_next.mode.bypass = 1'b0;
              OP_CHIP_ERASE:  s_next.mode.chip_erasing = 1'b1;
              OP_SECT_ERASE,
              OP_SECT_ADD:
              begin
                s_next.mode.erasing = 1'b1;
                s_next.win          = WIN_LOAD;
              end
              OP_SUSPEND:
              begin
                s_next.mode.suspended = 1'b1;
                s_next.win            = 11'h000;
              end
              OP_RESUME:      s_next.mode.suspended = 1'b0;
              default:        s_next.mode = s_reg.mode;
            endcase
          end
          else
          begin
            s_next.step = s_reg.step + 3'd1;
            s_next.st   = M_ISSUE;
          end
        end
      end
      default:
      begin
        s_next.st    = M_IDLE;
        s_next.ready = 1'b1;
      end
    endcase
    // Only the caller can see completion; status polling is not ours
    if (I_ERASE_DONE)
    begin
      s_next.mode.erasing      = 1'b0;
      s_next.mode.suspended    = 1'b0;
      s_next.mode.chip_erasing = 1'b0;
      s_next.win               = 11'h000;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      s_reg <= '{st: M_IDLE, op: OP_READ, addr: 20'h00000, data: 16'h0000, step: 3'd0,
                 mode: 7'h00, win: 11'h000, start: 1'b0, ready: 1'b0, done: 1'b0,
                 reject: 1'b0, rdata: 16'h0000};
    else
      s_reg <= s_next;
  end

  // Pins come straight from the cycle engine's flip-flops
  assign O_REQ_READY  = s_reg.ready;
  assign O_DONE       = s_reg.done;
  assign O_REJECT     = s_reg.reject;
  assign O_RD_DATA    = s_reg.rdata;
  assign O_MODE       = s_reg.mode;
  assign O_FL_CE_N    = bc_pins.ce_n;
  assign O_FL_WE_N    = bc_pins.we_n;
  assign O_FL_OE_N    = bc_pins.oe_n;
  assign O_FL_ADDR    = bc_pins.addr;
  assign O_FL_DQ_OUT  = bc_pins.dq_out;
  assign O_FL_DQ_OE_N = bc_pins.dq_oe_n;

endmodule : fwc_ctrl
`default_nettype wire

/* File: src/fwc_pkg.sv */
// Constants, command codes and carrier types for the word-mode flash command controller.
// Assumes a 20 MHz system clock and a 16-bit, 20-bit-address asynchronous NOR flash.
package fwc_pkg;

  // Command-cycle addresses, word mode
  localparam logic [19:0] ADDR_UNLOCK1 = 20'h00555;
  localparam logic [19:0] ADDR_UNLOCK2 = 20'h002aa;
  localparam logic [19:0] ADDR_CFI     = 20'h00055;
  localparam logic [19:0] ADDR_ANY     = 20'h00000;

  // Sector field of an address
  localparam int SECTOR_LSB = 12;
  localparam int SECTOR_MSB = 19;

  // Data codes, upper byte always driven as zero
  localparam logic [15:0] D_UNLOCK1       = 16'h00aa;
  localparam logic [15:0] D_UNLOCK2       = 16'h0055;
  localparam logic [15:0] CMD_RESET       = 16'h00f0;
  localparam logic [15:0] CMD_AUTOSEL     = 16'h0090;
  localparam logic [15:0] CMD_SECSI_ENTER = 16'h0088;
  localparam logic [15:0] CMD_SECSI_EXIT  = 16'h0000;
  localparam logic [15:0] CMD_CFI         = 16'h0098;
  localparam logic [15:0] CMD_PROGRAM     = 16'h00a0;
  localparam logic [15:0] CMD_BYPASS      = 16'h0020;
  localparam logic [15:0] CMD_ERASE_SETUP = 16'h0080;
  localparam logic [15:0] CMD_CHIP_ERASE  = 16'h0010;
  localparam logic [15:0] CMD_SECT_ERASE  = 16'h0030;
  localparam logic [15:0] CMD_SUSPEND     = 16'h00b0;
  localparam logic [15:0] CMD_RESUME      = 16'h0030;

  // Timing
  localparam int CLK_PERIOD_NS    = 50;
  localparam int T_SETUP_NS       = 50;
  localparam int T_WRITE_PULSE_NS = 100;
  localparam int T_ACCESS_NS      = 120;
  localparam int T_HOLD_NS        = 50;
  localparam int T_ERASE_WIN_US   = 50;

  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_min

  localparam int SETUP_CYC     = cyc_min(T_SETUP_NS);
  localparam int WRITE_CYC     = cyc_min(T_WRITE_PULSE_NS);
  localparam int ACCESS_CYC    = cyc_min(T_ACCESS_NS);
  localparam int HOLD_CYC      = cyc_min(T_HOLD_NS);
  // Longest time: rounds down
  localparam int ERASE_WIN_CYC = (T_ERASE_WIN_US * 1000) / CLK_PERIOD_NS;
  // Room needed to land one more write inside the window
  localparam int WIN_GUARD_CYC = SETUP_CYC + WRITE_CYC + HOLD_CYC + 4;

  typedef enum logic [3:0] {
    OP_READ        = 4'h0,
    OP_RESET       = 4'h1,
    OP_AUTOSEL     = 4'h2,
    OP_SECSI_ENTER = 4'h3,
    OP_SECSI_EXIT  = 4'h4,
    OP_CFI         = 4'h5,
    OP_PROGRAM     = 4'h6,
    OP_BYP_ENTER   = 4'h7,
    OP_BYP_PROGRAM = 4'h8,
    OP_BYP_RESET   = 4'h9,
    OP_CHIP_ERASE  = 4'ha,
    OP_SECT_ERASE  = 4'hb,
    OP_SECT_ADD    = 4'hc,
    OP_SUSPEND     = 4'hd,
    OP_RESUME      = 4'he
  } fwc_op_t;

  typedef struct packed {
    logic        rd;
    logic [19:0] addr;
    logic [15:0] data;
  } fwc_cyc_t;

  typedef struct packed {
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic [19:0] addr;
    logic [15:0] dq_out;
    logic        dq_oe_n;
  } fwc_pins_t;

  typedef struct packed {
    logic autosel;
    logic cfi;
    logic bypass;
    logic secsi;
    logic erasing;
    logic suspended;
    logic chip_erasing;
  } fwc_mode_t;

endpackage : fwc_pkg
